// File: src/card_irq_pkg.sv
// Constants for the card socket status change and interrupt block
// Function
// - A24 pin follows bit 1 in window mode
// - Attribute pin follows bit 0 otherwise
// - Flags clear on reset and hardware standby
// - Soft detect write needs detect enable
// - Pulse mode request flag cleared by zero
// - Level mode bit 5 reads inverted pin
// - Memory-only mode reads bits 5,4 zero
// - Status change flag sets on falling pin
// - Detect flag sets on either detect change
// - Ready flag sets on rising ready pin
// - I/O mode reads bits 2..0 zero
// - Warning flag re-evaluated on battery change
// - Dead flag re-evaluated on battery change
// - Battery pair: 11 good, 01 warn, else dead
// - Enable bits gate sources, cleared on reset
// - Reinit enable clears control on detect change
// - Mode 00 raises no card request interrupt; bit 5 still reads inverted pin
// - Mode 01 interrupts while request low
// - Mode 10 interrupts on falling request
// - Mode 11 interrupts on rising request
// - Enable 4 gates status change interrupt
// - Enable 3 gates detect change interrupt
// - Enable 2 gates ready rise interrupt
// - Enables 1,0 gate battery warn, dead
package card_irq_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_GENERAL_CONTROL = 8'h00;
	localparam logic [7:0] OFS_SOFTWARE_CONTROL = 8'h04;
	localparam logic [7:0] OFS_CHANGE_FLAGS = 8'h08;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0C;
	localparam logic [2:0] IDX_GCR = 3'h0;
	localparam logic [2:0] IDX_SCR = 3'h1;
	localparam logic [2:0] IDX_FLAGS = 3'h2;
	localparam logic [2:0] IDX_EN = 3'h3;
	localparam logic [2:0] IDX_NONE = 3'h4;
	localparam logic [7:0] GCR_RESET = 8'h00;
	localparam logic [3:0] SCR_RESET = 4'h0;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] EN_RESET = 8'h00;
	localparam int GCR_ATTR_BIT = 0;
	localparam int GCR_A24_BIT = 1;
	localparam int GCR_MMOD_BIT = 3;
	localparam int GCR_CARD_TYPE_BIT = 5;
	localparam int FL_SOFT_DETECT = 7;
	localparam int FL_CARD_IRQ = 5;
	localparam int FL_STAT_CHANGE = 4;
	localparam int FL_DETECT_CHANGE = 3;
	localparam int FL_READY_RISE = 2;
	localparam int FL_BATT_WARN = 1;
	localparam int FL_BATT_DEAD = 0;
	localparam int EN_REINIT = 7;
	localparam int EN_MODE_HI = 6;
	localparam int EN_MODE_LO = 5;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_LEVEL = 2'h1;
	localparam logic [1:0] MODE_FALL = 2'h2;
	localparam logic [1:0] MODE_RISE = 2'h3;
	localparam logic [1:0] BATT_GOOD = 2'h3;
	localparam logic [1:0] BATT_WARN = 2'h1;
	localparam int PIN_READY = 0;
	localparam int PIN_DET_A = 1;
	localparam int PIN_DET_B = 2;
	localparam int PIN_BATT_A = 3;
	localparam int PIN_BATT_B = 4;
	localparam int PIN_N = 5;
	// One past the synchroniser delay, so the edge detector's previous level is real too
	localparam logic [2:0] SETTLE_CYCLES = 3'h5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic ATTR_IDLE = 1'b1;
endpackage : card_irq_pkg

// File: src/card_socket_status_change_irq.sv
// Card socket status change flags, interrupt enables and socket pin controls
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module card_socket_status_change_irq (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic hw_standby,
	input wire logic common_access,
	input wire logic card_access,
	input wire logic socket_ready_pin,
	input wire logic socket_detect_pin_a,
	input wire logic socket_detect_pin_b,
	input wire logic socket_batt_pin_a,
	input wire logic socket_batt_pin_b,
	output logic socket_addr_b24_pin,
	output logic socket_attr_select_pin,
	output logic socket_irq
);
	function automatic logic [2:0] reg_index(input logic [7:0] addr);
		logic [2:0] idx;
		idx = card_irq_pkg::IDX_NONE;
		case (addr)
			card_irq_pkg::OFS_GENERAL_CONTROL: idx = card_irq_pkg::IDX_GCR;
			card_irq_pkg::OFS_SOFTWARE_CONTROL: idx = card_irq_pkg::IDX_SCR;
			card_irq_pkg::OFS_CHANGE_FLAGS: idx = card_irq_pkg::IDX_FLAGS;
			card_irq_pkg::OFS_IRQ_ENABLE: idx = card_irq_pkg::IDX_EN;
			default: idx = card_irq_pkg::IDX_NONE;
		endcase
		return idx;
	endfunction : reg_index

	// Returns {warn, dead} for the pair {second, first}
	function automatic logic [1:0] batt_state(input logic [1:0] pair);
		logic [1:0] st;
		st = 2'h0;
		if (pair == card_irq_pkg::BATT_GOOD) begin
			st = 2'h0;
		end else if (pair == card_irq_pkg::BATT_WARN) begin
			st = 2'h2;
		end else begin
			st = 2'h1;
		end
		return st;
	endfunction : batt_state

	logic awready_ff;
	logic wready_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic arready_ff;
	logic rvalid_ff;
	logic [1:0] rresp_ff;
	logic [31:0] rdata_ff;
	logic [7:0] awaddr_ff;
	logic [7:0] wdata_ff;
	logic wstrb0_ff;
	logic [7:0] gcr_ff;
	logic [3:0] scr_ff;
	logic [7:0] en_ff;
	logic [7:0] flags_ff;
	logic [card_irq_pkg::PIN_N-1:0] prev_ff;
	logic [2:0] settle_ff;
	logic a24_ff;
	logic attr_ff;
	logic irq_ff;

	wire logic [card_irq_pkg::PIN_N-1:0] pin_raw;
	wire logic [card_irq_pkg::PIN_N-1:0] pin_lvl;
	assign pin_raw = {socket_batt_pin_b, socket_batt_pin_a, socket_detect_pin_b,
		socket_detect_pin_a, socket_ready_pin};

	generate
		for (genvar gi = 0; gi < card_irq_pkg::PIN_N; gi++) begin : g_sync
			pin_sync u_sync (
				.aclk(aclk),
				.aresetn(aresetn),
				.pin(pin_raw[gi]),
				.level(pin_lvl[gi])
			);
		end
	endgenerate

	// Events held off until the synchronisers hold real pin levels
	wire logic ev_ok;
	wire logic [card_irq_pkg::PIN_N-1:0] pin_rise;
	wire logic [card_irq_pkg::PIN_N-1:0] pin_fall;
	wire logic [card_irq_pkg::PIN_N-1:0] pin_chg;
	assign ev_ok = (settle_ff == card_irq_pkg::SETTLE_CYCLES);
	assign pin_rise = ev_ok ? (pin_lvl & ~prev_ff) : '0;
	assign pin_fall = ev_ok ? (~pin_lvl & prev_ff) : '0;
	assign pin_chg = pin_rise | pin_fall;

	wire logic io_mode;
	wire logic mmod;
	wire logic [1:0] irq_mode;
	wire logic pulse_mode;
	wire logic level_mode;
	wire logic ready_lvl;
	assign io_mode = gcr_ff[card_irq_pkg::GCR_CARD_TYPE_BIT];
	assign mmod = gcr_ff[card_irq_pkg::GCR_MMOD_BIT];
	assign irq_mode = en_ff[card_irq_pkg::EN_MODE_HI:card_irq_pkg::EN_MODE_LO];
	assign pulse_mode = irq_mode[1];
	assign level_mode = (irq_mode == card_irq_pkg::MODE_LEVEL);
	assign ready_lvl = pin_lvl[card_irq_pkg::PIN_READY];

	// Write path: commit once both address and data are held
	wire logic wr_go;
	wire logic [2:0] wr_idx;
	wire logic wr_lane;
	wire logic wr_gcr;
	wire logic wr_scr;
	wire logic wr_fl;
	wire logic wr_en;
	assign wr_go = !awready_ff && !wready_ff && !bvalid_ff;
	assign wr_idx = reg_index(awaddr_ff);
	assign wr_lane = wr_go && wstrb0_ff;
	assign wr_gcr = wr_lane && (wr_idx == card_irq_pkg::IDX_GCR);
	assign wr_scr = wr_lane && (wr_idx == card_irq_pkg::IDX_SCR);
	assign wr_fl = wr_lane && (wr_idx == card_irq_pkg::IDX_FLAGS);
	assign wr_en = wr_lane && (wr_idx == card_irq_pkg::IDX_EN);

	wire logic detect_evt;
	wire logic reinit;
	assign detect_evt = pin_chg[card_irq_pkg::PIN_DET_A] | pin_chg[card_irq_pkg::PIN_DET_B];
	assign reinit = detect_evt && en_ff[card_irq_pkg::EN_REINIT];

	wire logic [7:0] nxt_gcr;
	wire logic [3:0] nxt_scr;
	assign nxt_gcr = reinit ? card_irq_pkg::GCR_RESET : (wr_gcr ? wdata_ff : gcr_ff);
	assign nxt_scr = reinit ? card_irq_pkg::SCR_RESET : (wr_scr ? wdata_ff[3:0] : scr_ff);

	// Flag sources; a set in the same cycle as a clear wins
	wire logic [7:0] fl_clr;
	wire logic edge_evt;
	wire logic set_soft;
	wire logic set_irq;
	wire logic set_stat;
	wire logic set_det;
	wire logic set_rdy;
	wire logic batt_load;
	wire logic [1:0] batt_now;
	assign fl_clr = wr_fl ? ~wdata_ff : 8'h00;
	assign set_soft = wr_fl && wdata_ff[card_irq_pkg::FL_SOFT_DETECT] &&
		en_ff[card_irq_pkg::FL_DETECT_CHANGE];
	assign edge_evt = (irq_mode == card_irq_pkg::MODE_FALL) ? pin_fall[card_irq_pkg::PIN_READY]
		: pin_rise[card_irq_pkg::PIN_READY];
	assign set_irq = io_mode && pulse_mode && edge_evt;
	assign set_stat = io_mode && pin_fall[card_irq_pkg::PIN_BATT_A];
	assign set_det = detect_evt;
	assign set_rdy = !io_mode && pin_rise[card_irq_pkg::PIN_READY];
	assign batt_load = !io_mode && (pin_chg[card_irq_pkg::PIN_BATT_A] | pin_chg[card_irq_pkg::PIN_BATT_B]);
	assign batt_now = batt_state({pin_lvl[card_irq_pkg::PIN_BATT_B], pin_lvl[card_irq_pkg::PIN_BATT_A]});

	wire logic [7:0] nxt_flags;
	assign nxt_flags[7] = set_soft | (flags_ff[7] & ~fl_clr[7]);
	assign nxt_flags[6] = 1'b0;
	assign nxt_flags[5] = pulse_mode & (set_irq | (flags_ff[5] & ~fl_clr[5]));
	assign nxt_flags[4] = set_stat | (flags_ff[4] & ~fl_clr[4]);
	assign nxt_flags[3] = set_det | (flags_ff[3] & ~fl_clr[3]);
	assign nxt_flags[2] = set_rdy | (flags_ff[2] & ~fl_clr[2]);
	assign nxt_flags[1] = batt_load ? batt_now[1] : (flags_ff[1] & ~fl_clr[1]);
	assign nxt_flags[0] = batt_load ? batt_now[0] : (flags_ff[0] & ~fl_clr[0]);

	// What software sees; mode-dependent bits are masked here, not stored
	wire logic view_irq;
	wire logic [7:0] flag_view;
	assign view_irq = io_mode && (pulse_mode ? flags_ff[5] : !ready_lvl);
	assign flag_view = {flags_ff[7], 1'b0, view_irq,
		io_mode & flags_ff[4],
		flags_ff[3],
		io_mode ? 3'h0 : flags_ff[2:0]};

	wire logic nxt_irq;
	assign nxt_irq = (|(flag_view[4:0] & en_ff[4:0]))
		| (flags_ff[7] & en_ff[card_irq_pkg::FL_DETECT_CHANGE])
		| (io_mode & pulse_mode & flags_ff[5])
		| (io_mode & level_mode & !ready_lvl);

	wire logic nxt_a24;
	wire logic nxt_attr;
	assign nxt_a24 = (mmod && common_access) ? gcr_ff[card_irq_pkg::GCR_A24_BIT] : 1'b0;
	assign nxt_attr = (!mmod && card_access) ? gcr_ff[card_irq_pkg::GCR_ATTR_BIT]
		: card_irq_pkg::ATTR_IDLE;

	wire logic [2:0] rd_idx;
	wire logic [7:0] rd_byte;
	assign rd_idx = reg_index(araddr);
	assign rd_byte = (rd_idx == card_irq_pkg::IDX_GCR) ? gcr_ff
		: (rd_idx == card_irq_pkg::IDX_SCR) ? {4'h0, scr_ff}
		: (rd_idx == card_irq_pkg::IDX_FLAGS) ? flag_view
		: (rd_idx == card_irq_pkg::IDX_EN) ? en_ff : 8'h00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			bvalid_ff <= 1'b0;
			bresp_ff <= card_irq_pkg::RESP_OKAY;
			awaddr_ff <= 8'h00;
			wdata_ff <= 8'h00;
			wstrb0_ff <= 1'b0;
		end else begin
			if (awvalid && awready_ff) begin
				awaddr_ff <= awaddr;
				awready_ff <= 1'b0;
			end
			if (wvalid && wready_ff) begin
				wdata_ff <= wdata[7:0];
				wstrb0_ff <= wstrb[0];
				wready_ff <= 1'b0;
			end
			if (wr_go) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= (wr_idx == card_irq_pkg::IDX_NONE) ? card_irq_pkg::RESP_SLVERR
					: card_irq_pkg::RESP_OKAY;
			end else if (bvalid_ff && bready) begin
				bvalid_ff <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rresp_ff <= card_irq_pkg::RESP_OKAY;
			rdata_ff <= 32'h00000000;
		end else if (arvalid && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rdata_ff <= {24'h000000, rd_byte};
			rresp_ff <= (rd_idx == card_irq_pkg::IDX_NONE) ? card_irq_pkg::RESP_SLVERR
				: card_irq_pkg::RESP_OKAY;
		end else if (rvalid_ff && rready) begin
			rvalid_ff <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gcr_ff <= card_irq_pkg::GCR_RESET;
			scr_ff <= card_irq_pkg::SCR_RESET;
			en_ff <= card_irq_pkg::EN_RESET;
		end else begin
			gcr_ff <= nxt_gcr;
			scr_ff <= nxt_scr;
			if (wr_en) begin
				en_ff <= wdata_ff;
			end
		end
	end

	// Hardware standby wipes the flags but keeps the enables
	always_ff @(posedge aclk) begin
		if (!aresetn || hw_standby) begin
			flags_ff <= card_irq_pkg::FLAGS_RESET;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_ff <= '0;
			settle_ff <= 3'h0;
			a24_ff <= 1'b0;
			attr_ff <= card_irq_pkg::ATTR_IDLE;
			irq_ff <= 1'b0;
		end else begin
			prev_ff <= pin_lvl;
			if (!ev_ok) begin
				settle_ff <= settle_ff + 3'h1;
			end
			a24_ff <= nxt_a24;
			attr_ff <= nxt_attr;
			irq_ff <= nxt_irq;
		end
	end

	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rresp = rresp_ff;
	assign rdata = rdata_ff;
	assign socket_addr_b24_pin = a24_ff;
	assign socket_attr_select_pin = attr_ff;
	assign socket_irq = irq_ff;

	a_addr24_drive: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(mmod && common_access) |-> a24_ff == $past(gcr_ff[card_irq_pkg::GCR_A24_BIT]))
		else $error("a24 pin does not follow control bit 1");
	a_attr_drive: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(!mmod && card_access) |-> attr_ff == $past(gcr_ff[card_irq_pkg::GCR_ATTR_BIT]))
		else $error("attribute pin does not follow control bit 0");
	a_standby_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		hw_standby |=> flags_ff == card_irq_pkg::FLAGS_RESET)
		else $error("flags survived hardware standby");
	a_soft_gate: assert property (@(posedge aclk) disable iff (!aresetn || hw_standby)
		wr_fl && wdata_ff[7] |=> flags_ff[7] == $past(en_ff[3] | flags_ff[7]))
		else $error("soft detect write ignored its enable");
	a_level_view: assert property (@(posedge aclk) disable iff (!aresetn)
		io_mode && !pulse_mode |-> flag_view[5] == !ready_lvl)
		else $error("level mode bit 5 not inverted pin");
	a_mem_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		!io_mode |-> flag_view[5:4] == 2'h0)
		else $error("memory mode shows request bits");
	a_io_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		io_mode |-> flag_view[2:0] == 3'h0)
		else $error("io mode shows ready or battery bits");
	a_stat_set: assert property (@(posedge aclk) disable iff (!aresetn || hw_standby)
		io_mode && pin_fall[card_irq_pkg::PIN_BATT_A] |=> flags_ff[4])
		else $error("status change edge lost");
	a_detect_set: assert property (@(posedge aclk) disable iff (!aresetn || hw_standby)
		detect_evt |=> flags_ff[3])
		else $error("detect change lost");
	a_batt_eval: assert property (@(posedge aclk) disable iff (!aresetn || hw_standby)
		batt_load |=> flags_ff[1:0] == batt_state($past({pin_lvl[4], pin_lvl[3]})))
		else $error("battery flags not re-evaluated");
	a_reinit_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		reinit |=> gcr_ff == card_irq_pkg::GCR_RESET && scr_ff == card_irq_pkg::SCR_RESET)
		else $error("control not reinitialised on detect change");
	a_level_irq: assert property (@(posedge aclk) disable iff (!aresetn)
		io_mode && level_mode && !ready_lvl |=> socket_irq)
		else $error("level request did not interrupt");
	a_irq_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		(en_ff[4:0] == 5'h00) && (irq_mode == card_irq_pkg::MODE_OFF) && !en_ff[3] |=> !socket_irq)
		else $error("interrupt with every source disabled");
endmodule : card_socket_status_change_irq

// File: src/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin,
	output logic level
);
	logic meta_ff;
	logic s2_ff;
	logic s3_ff;
	logic level_ff;

	// Only s2 and s3 are compared; meta_ff feeds s2 alone
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			level_ff <= 1'b0;
		end else begin
			meta_ff <= pin;
			s2_ff <= meta_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				level_ff <= s3_ff;
			end
		end
	end

	assign level = level_ff;
endmodule : pin_sync

// File: tb/card_socket_model.sv
// Card side of the socket: detect, ready and battery pins
`timescale 1ns/1ps
module card_socket_model (
	output logic socket_ready_pin,
	output logic socket_detect_pin_a,
	output logic socket_detect_pin_b,
	output logic socket_batt_pin_a,
	output logic socket_batt_pin_b
);
	// Card seated, ready, battery good
	logic [card_irq_pkg::PIN_N-1:0] pins = 5'h19;

	assign socket_ready_pin = pins[card_irq_pkg::PIN_READY];
	assign socket_detect_pin_a = pins[card_irq_pkg::PIN_DET_A];
	assign socket_detect_pin_b = pins[card_irq_pkg::PIN_DET_B];
	assign socket_batt_pin_a = pins[card_irq_pkg::PIN_BATT_A];
	assign socket_batt_pin_b = pins[card_irq_pkg::PIN_BATT_B];

	// Card pins are asynchronous, so each change lands at a random offset from the clock
	task automatic drive(input int idx, input logic v);
		#(3 + $urandom_range(30));
		pins[idx] = v;
	endtask : drive
endmodule : card_socket_model

// File: tb/card_socket_status_change_irq_tb.sv
// Self-checking bench for the card socket status change and interrupt block
`timescale 1ns/1ps
module card_socket_status_change_irq_tb;
	localparam logic [7:0] A_G = card_irq_pkg::OFS_GENERAL_CONTROL;
	localparam logic [7:0] A_S = card_irq_pkg::OFS_SOFTWARE_CONTROL;
	localparam logic [7:0] A_F = card_irq_pkg::OFS_CHANGE_FLAGS;
	localparam logic [7:0] A_E = card_irq_pkg::OFS_IRQ_ENABLE;
	// Request flag and interrupt per mode, after the pin goes low and after it returns high
	localparam logic [3:0] LO_B5 = 4'h7;
	localparam logic [3:0] LO_IRQ = 4'h6;
	localparam logic [3:0] HI_B5 = 4'hC;
	localparam logic [3:0] HI_IRQ = 4'hC;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, hw_standby, common_access, card_access;
	logic awready, wready, bvalid, arready, rvalid, socket_addr_b24_pin, socket_attr_select_pin, socket_irq;
	logic socket_ready_pin, socket_detect_pin_a, socket_detect_pin_b, socket_batt_pin_a, socket_batt_pin_b;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	int miscompares = 0;
	int num_checks = 0;

	card_socket_status_change_irq card_socket_status_change_irq_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .hw_standby, .common_access, .card_access, .socket_ready_pin, .socket_detect_pin_a,
		.socket_detect_pin_b, .socket_batt_pin_a, .socket_batt_pin_b, .socket_addr_b24_pin, .socket_attr_select_pin,
		.socket_irq);

	card_socket_model card_socket_model_inst (.socket_ready_pin, .socket_detect_pin_a, .socket_detect_pin_b,
		.socket_batt_pin_a, .socket_batt_pin_b);

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	task automatic timeout;
		check("handshake", 32'h0, 32'h1);
		tally_and_finish();
	endtask : timeout

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = card_irq_pkg::RESP_OKAY);
		int n;
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		// Response ready stays up between writes, so back-to-back calls never drive it twice in one step
		if (n == 40) timeout();
		check("write response", bresp, er);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata[7:0];
		r = rresp;
		if (n == 40) timeout();
	endtask : rd

	task automatic rc(input logic [7:0] a, input logic [7:0] e, input string w);
		logic [7:0] d;
		logic [1:0] r;
		rd(a, d, r);
		check(w, {r, 22'h0, d}, {card_irq_pkg::RESP_OKAY, 22'h0, e});
	endtask : rc

	// Covers synchroniser, agreement filter, flag and interrupt register
	task automatic settle;
		repeat (8) @(posedge aclk);
	endtask : settle

	task automatic pin(input int i, input logic v);
		card_socket_model_inst.drive(i, v);
		settle();
	endtask : pin

	task automatic done(input string t);
		$display("test %s finished", t);
	endtask : done

	function automatic logic [1:0] exp_batt(input logic [1:0] ba);
		if (ba == 2'h3)
			return 2'h0;
		return (ba == 2'h1) ? 2'h2 : 2'h1;
	endfunction : exp_batt

	initial begin
		logic [7:0] g;
		logic [7:0] d;
		logic [1:0] r;
		logic [1:0] bp;
		logic ca;
		logic cd;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, hw_standby, common_access, card_access} = 9'h000;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		void'($urandom(32'hBC99BAF4));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		settle();
		rc(A_F, 8'h00, "flags at reset");
		rc(A_E, 8'h00, "enable at reset");
		rd(8'h10, d, r);
		check("unmapped read", {r, 22'h0, d}, {card_irq_pkg::RESP_SLVERR, 30'h0});
		wr(8'h10, 8'hFF, card_irq_pkg::RESP_SLVERR);
		check("irq idle", socket_irq, 1'b0);
		g = 8'($urandom());
		wr(A_E, g);
		rc(A_E, g, "enable readback");
		wr(A_E, 8'h00);
		done("registers");
		for (int i = 0; i < 8; i++) begin
			ca = 1'($urandom());
			cd = 1'($urandom());
			wr(A_G, {4'h0, i[2], 1'b0, i[1], i[0]});
			common_access <= ca;
			card_access <= cd;
			repeat (3) @(posedge aclk);
			check("a24 pin", socket_addr_b24_pin, i[2] & i[1] & ca);
			check("attr pin", socket_attr_select_pin, (!i[2] && cd) ? i[0] : 1'b1);
		end
		done("address pins");
		wr(A_G, 8'h00);
		wr(A_E, 8'h04);
		pin(card_irq_pkg::PIN_READY, 1'b0);
		rc(A_F, 8'h00, "memory mode request bit");
		pin(card_irq_pkg::PIN_READY, 1'b1);
		rc(A_F, 8'h04, "ready rise");
		check("ready irq", socket_irq, 1'b1);
		wr(A_E, 8'h00);
		wr(A_F, 8'hFF);
		rc(A_F, 8'h04, "write ones keeps flags");
		check("ready irq masked", socket_irq, 1'b0);
		wr(A_F, 8'hFB);
		rc(A_F, 8'h00, "ready clear");
		wr(A_E, 8'h03);
		bp = 2'h3;
		for (int i = 0; i < 4; i++) begin
			bp[!i[0]] = i[1];
			pin(i[0] ? card_irq_pkg::PIN_BATT_A : card_irq_pkg::PIN_BATT_B, i[1]);
			rc(A_F, {6'h0, exp_batt(bp)}, "battery flags");
			check("battery irq", socket_irq, |exp_batt(bp));
		end
		done("memory card");
		wr(A_E, 8'h88);
		g = 8'($urandom()) & 8'hDF;
		wr(A_G, g);
		wr(A_S, 8'h0A);
		pin(card_irq_pkg::PIN_DET_A, 1'b1);
		rc(A_F, 8'h08, "detect change");
		check("detect irq", socket_irq, 1'b1);
		rc(A_G, 8'h00, "reinit general control");
		rc(A_S, 8'h00, "reinit software control");
		wr(A_E, 8'h08);
		wr(A_F, 8'h77);
		wr(A_G, g);
		pin(card_irq_pkg::PIN_DET_B, 1'b1);
		rc(A_F, 8'h08, "detect change second pin");
		rc(A_G, g, "control kept");
		wr(A_F, 8'h77);
		wr(A_F, 8'h80);
		rc(A_F, 8'h80, "soft detect");
		check("soft detect irq", socket_irq, 1'b1);
		hw_standby <= 1'b1;
		settle();
		hw_standby <= 1'b0;
		rc(A_F, 8'h00, "standby clears flags");
		check("irq after standby", socket_irq, 1'b0);
		done("detect");
		wr(A_G, 8'h20);
		wr(A_E, 8'h10);
		pin(card_irq_pkg::PIN_BATT_A, 1'b0);
		rc(A_F, 8'h10, "status change");
		check("status irq", socket_irq, 1'b1);
		wr(A_F, 8'h6F);
		rc(A_F, 8'h00, "status clear");
		wr(A_E, 8'h00);
		pin(card_irq_pkg::PIN_BATT_A, 1'b1);
		pin(card_irq_pkg::PIN_BATT_A, 1'b0);
		check("status masked", socket_irq, 1'b0);
		wr(A_F, 8'h6F);
		for (int m = 0; m < 4; m++) begin
			wr(A_E, {1'b0, 2'(m), 5'h00});
			pin(card_irq_pkg::PIN_READY, 1'b0);
			rc(A_F, {2'h0, LO_B5[m], 5'h00}, "request low");
			check("request low irq", socket_irq, LO_IRQ[m]);
			pin(card_irq_pkg::PIN_READY, 1'b1);
			wr(A_F, 8'h7F);
			rc(A_F, {2'h0, HI_B5[m], 5'h00}, "request high");
			check("request high irq", socket_irq, HI_IRQ[m]);
			wr(A_F, 8'h00);
		end
		done("io card");
		tally_and_finish();
	end
endmodule : card_socket_status_change_irq_tb
